/* File: sram_host_ctl.sv */
// Purpose: host controller sequencing an asynchronous 256k x 4 static memory
// Assumes: one request at a time; memory pins wired straight to outputs
// Notes: every pin output is a flip-flop
// Overview of operation
// RULE1 - memory holds 262144 four-bit words, 18-bit address, shared 4-bit data
// RULE2 - memory is static; controller needs no refresh or clocking of it
// RULE3 - select high deselects the memory, its data lines float
// RULE4 - selected without write or output drive, memory floats its data lines
// RULE5 - read holds strobe high, select and output drive low
// RULE6 - after address change the memory drives the new word
// RULE7 - memory stores only while select and strobe both low
// RULE8 - write spans later falling to earlier rising of select and strobe
// RULE9 - select falling with or after strobe keeps memory data floating
// RULE10 - memory resumes driving no sooner than 3 ns after write ends
// RULE11 - write pulse at least 8 ns with drive off, longer with drive on
// RULE12 - at read levels the memory drives its data lines
// RULE13 - controller never drives data while the memory drives
// RULE14 - sequencing keeps overlap of both drivers minimal or absent
// RULE15 - address and data stay stable across the whole write overlap
`include "sram_cfg.svh"
module sram_host_ctl #(
  parameter int AW = `SRAM_ADDR_W,
  parameter int DW = `SRAM_DATA_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  output logic [AW-1:0] word_address,
  output logic select_n,
  output logic strobe_n,
  output logic drive_n,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe
);
  // ****************************************
  // pin input crossing
  // ****************************************
  logic [DW-1:0] data_sync;
  pin_sync #(.W(DW)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(data_in),
    .q(data_sync)
  );
  // ****************************************
  // sequencer state
  // ****************************************
  sram_pkg::ctl_state_t st_q, st_d;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wd_q, wd_d;
  logic sel_q, sel_d;
  logic stb_q, stb_d;
  logic drv_q, drv_d;
  logic oe_q, oe_d;
  logic rdy_q, rdy_d;
  logic rv_q, rv_d;
  logic [DW-1:0] rd_q, rd_d;
  logic take;
  logic sample_now;
  // a request is only looked at while parked, so a held request is not taken again before the current operation ends
  assign take = (st_q == sram_pkg::ST_IDLE) && req_valid && rdy_q;
  assign sample_now = (st_q == sram_pkg::ST_READ) && (cnt_q == `CNT_ZERO);
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    stb_d = stb_q;
    drv_d = drv_q;
    oe_d = oe_q;
    rdy_d = rdy_q;
    case (st_q)
      sram_pkg::ST_IDLE: begin
        // idle: deselected, nobody drives
        sel_d = 1'b1; // RULE3
        stb_d = 1'b1;
        drv_d = 1'b1; // RULE4
        oe_d = 1'b0;
        if (take) begin
          rdy_d = 1'b0;
          if (req_write) begin
            // strobe low before select, so memory never drives: RULE9
            stb_d = 1'b0; // RULE9
            oe_d = 1'b1; // RULE13
            st_d = sram_pkg::ST_WSET;
          end else begin
            sel_d = 1'b0; // RULE5
            drv_d = 1'b0; // RULE12
            cnt_d = `CNT_W'(`RC_CYC + 1);
            st_d = sram_pkg::ST_READ;
          end
        end
      end
      sram_pkg::ST_WSET: begin
        // select falls last: write begins here
        sel_d = 1'b0; // RULE8
        cnt_d = `CNT_W'(`WP_CYC);
        st_d = sram_pkg::ST_WPUL;
      end
      sram_pkg::ST_WPUL: begin
        // address and data held constant through the overlap
        if (cnt_q <= `CNT_ONE) begin
          stb_d = 1'b1; // RULE11
          sel_d = 1'b1; // RULE7
          st_d = sram_pkg::ST_WREC;
          cnt_d = `CNT_W'(`OW_CYC);
        end else begin
          cnt_d = cnt_q - `CNT_ONE; // RULE15
        end
      end
      sram_pkg::ST_WREC: begin
        // release data one cycle after the write ends: hold time margin
        oe_d = 1'b0; // RULE14
        if (cnt_q <= `CNT_ONE) begin
          rdy_d = 1'b1;
          st_d = sram_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - `CNT_ONE; // RULE10
        end
      end
      sram_pkg::ST_READ: begin
        // extra cycle covers the two-stage synchroniser
        if (sample_now) begin
          sel_d = 1'b1;
          drv_d = 1'b1;
          rdy_d = 1'b1;
          st_d = sram_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - `CNT_ONE; // RULE2
        end
      end
      default: begin
        st_d = sram_pkg::ST_IDLE;
        sel_d = 1'b1;
        stb_d = 1'b1;
        drv_d = 1'b1;
        oe_d = 1'b0;
        rdy_d = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= sram_pkg::ST_IDLE;
      cnt_q <= `CNT_ZERO;
      sel_q <= 1'b1;
      stb_q <= 1'b1;
      drv_q <= 1'b1;
      oe_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      stb_q <= stb_d;
      drv_q <= drv_d;
      oe_q <= oe_d;
      rdy_q <= rdy_d;
    end
  end
  // ****************************************
  // address and write data capture
  // ****************************************
  // frozen from take to the next take, so the word cannot move under a write
  always_comb begin
    addr_d = addr_q;
    wd_d = wd_q;
    if (take) begin
      addr_d = req_addr; // RULE15
      wd_d = req_wdata; // RULE15
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= '0;
      wd_q <= '0;
    end else begin
      addr_q <= addr_d;
      wd_q <= wd_d;
    end
  end
  // ****************************************
  // read response
  // ****************************************
  // sampled three edges after select: two for the synchroniser, one for access time
  always_comb begin
    rv_d = 1'b0;
    rd_d = rd_q;
    if (sample_now) begin
      rd_d = data_sync; // RULE5
      rv_d = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rv_q <= 1'b0;
      rd_q <= '0;
    end else begin
      rv_q <= rv_d;
      rd_q <= rd_d;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign req_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rd_q;
  assign word_address = addr_q;
  assign select_n = sel_q;
  assign strobe_n = stb_q;
  assign drive_n = drv_q;
  assign data_out = wd_q;
  assign data_oe = oe_q;
endmodule : sram_host_ctl

/* File: sram_cfg.svh */
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH
// ****************************************
// geometry
// ****************************************
`define SRAM_ADDR_W 18
`define SRAM_DATA_W 4
// ****************************************
// timing, in ns, and cycle counts at clk rate
// ****************************************
`define CLK_PERIOD_NS 50
// slowest grade write pulse with output drive held off
`define WP_NS 8
// read cycle time of slowest grade
`define RC_NS 12
// output return after write end
`define OW_NS 3
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WP_CYC `CEIL_CYC(`WP_NS)
`define RC_CYC `CEIL_CYC(`RC_NS)
`define OW_CYC `CEIL_CYC(`OW_NS)
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`endif

/* File: sram_pkg.sv */
// Purpose: shared types of the memory controller
// Assumes: nothing
// Notes: states are one-hot
package sram_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WSET = 5'h02,
    ST_WPUL = 5'h04,
    ST_WREC = 5'h08,
    ST_READ = 5'h10
  } ctl_state_t;
endpackage : sram_pkg

/* File: pin_sync.sv */
// Purpose: two flip-flop synchroniser per bit
// Assumes: d comes from another domain
// Notes: first stage feeds only the second
module pin_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= d[i];
          s2_q[i] <= s1_q[i];
        end
      end
    end
  endgenerate
  assign q = s2_q;
endmodule : pin_sync

/* File: ctl_asserts.sv */
// Purpose: pin sequencing checks of the host controller
// Assumes: one request at a time, pins registered
// Notes: bound into every controller instance
module ctl_asserts #(
  parameter int AW = 18,
  parameter int DW = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic select_n,
  input wire logic strobe_n,
  input wire logic drive_n,
  input wire logic data_oe,
  input wire logic [AW-1:0] word_address,
  input wire logic [DW-1:0] data_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence take_s(w);
    req_valid && req_ready && req_write == w;
  endsequence
  // strobe leads select so the memory never turns its drivers on
  sequence wr_s;
    !strobe_n && select_n && data_oe ##1 !select_n && !strobe_n ##1 select_n && strobe_n
    ##1 !data_oe && req_ready;
  endsequence
  sequence rd_s;
    (!select_n && !drive_n && strobe_n)[*3] ##1 rsp_valid && select_n && drive_n;
  endsequence
  write_walk_a: assert property (take_s(1) |=> wr_s) else $error("bad write walk");
  read_walk_a: assert property (take_s(0) |=> rd_s) else $error("bad read walk");
  no_contention_a: assert property (data_oe |-> !(!select_n && strobe_n && !drive_n))
    else $error("bus contention");
  drive_off_a: assert property (!strobe_n |-> drive_n) else $error("drive on in write");
  pulse_len_a: assert property ($fell(strobe_n) |-> !strobe_n[*2] ##1 strobe_n)
    else $error("bad pulse length");
  addr_hold_a: assert property (!select_n && $past(!select_n) |-> $stable(word_address))
    else $error("address moved");
  data_hold_a: assert property (!strobe_n && $past(!strobe_n) |-> $stable(data_out))
    else $error("data moved");
  release_a: assert property ($rose(strobe_n) |=> !data_oe) else $error("late release");
  idle_pins_a: assert property (req_ready |-> select_n && strobe_n && !data_oe)
    else $error("pins busy when idle");
endmodule : ctl_asserts
bind sram_host_ctl ctl_asserts #(.AW(AW), .DW(DW)) u_ctl_asserts (.*);

/* File: sram_model.sv */
// Purpose: behavioural static memory on the controller pins
// Assumes: controller resolves nothing; this model forms the wire
// Notes: released lines show the inverse of the last driven value
module sram_model (
  input wire logic [17:0] word_address,
  input wire logic select_n,
  input wire logic strobe_n,
  input wire logic drive_n,
  input wire logic [3:0] data_out,
  input wire logic data_oe,
  output logic [3:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem [0:262143];
  logic [3:0] last_q;
  wire rd = !select_n && strobe_n && !drive_n;
  wire wr = !select_n && !strobe_n;
  logic rd_on = 1'b0;
  // drivers follow the read levels 3 ns late, never at once after a write
  always @(rd) rd_on <= #3 rd;
  // floating lines must not look like held data
  always_comb data_in = data_oe ? data_out : rd_on ? mem[word_address] : ~last_q;
  always @(data_in) if (data_oe || rd_on) last_q = data_in;
  always @(negedge wr) mem[word_address] = data_in;
endmodule : sram_model

/* File: tb_sram_host_ctl.sv */
// Purpose: self-checking bench of the host controller
// Assumes: memory model on the pins
// Notes: requests raised one edge after the previous write is taken or the previous read is answered
module tb_sram_host_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [17:0] req_addr = 18'h00000, word_address;
  logic [3:0] req_wdata = 4'h0, rsp_rdata, data_in, data_out;
  logic req_ready, rsp_valid, select_n, strobe_n, drive_n, data_oe;
  int err_total = 0, n_checks = 0;
  always #25 clk = ~clk;
  sram_host_ctl u_sram_host_ctl (.*);
  sram_model u_sram_model (.*);
  task automatic results();
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic fail(string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk(logic [3:0] g, logic [3:0] e);
    n_checks++;
    if (g !== e) fail("value mismatch");
  endtask : chk
  task automatic op(logic w, logic [17:0] a, logic [3:0] d, output logic [3:0] q);
    int i;
    logic took;
    i = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do begin @(posedge clk); i++; end while (req_ready !== 1'b1 && i < 10);
    took = (req_ready === 1'b1);
    req_valid <= 1'b0;
    while (took && !w && rsp_valid !== 1'b1 && i < 20) begin @(posedge clk); i++; end
    if (!took || (!w && rsp_valid !== 1'b1)) begin
      fail("timeout");
      results();
    end
    q = rsp_rdata;
  endtask : op
  task automatic t_fill();
    logic [17:0] a [3] = '{18'h00000, 18'h3FFFF, 18'h15555};
    logic [3:0] q;
    for (int k = 0; k < 3; k++) op(1'b1, a[k], 4'hA ^ 4'(k), q);
    for (int k = 0; k < 3; k++) begin
      op(1'b0, a[k], 4'h0, q);
      chk(q, 4'hA ^ 4'(k));
    end
  endtask : t_fill
  task automatic t_overwrite();
    logic [3:0] q;
    op(1'b1, 18'h00001, 4'h0, q);
    op(1'b1, 18'h00001, 4'hF, q);
    op(1'b0, 18'h00001, 4'h0, q);
    chk(q, 4'hF);
  endtask : t_overwrite
  // reset on the take edge of a write cancels it before select falls: word keeps its value
  task automatic t_reset();
    logic [3:0] q;
    op(1'b1, 18'h00001, 4'h5, q);
    resetn <= 1'b0;
    @(negedge clk);
    chk({1'b0, select_n, strobe_n, data_oe}, 4'h6);
    @(posedge clk);
    resetn <= 1'b1;
    op(1'b0, 18'h00001, 4'h0, q);
    chk(q, 4'hF);
  endtask : t_reset
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_fill();
    t_overwrite();
    t_reset();
    results();
  end
endmodule : tb_sram_host_ctl
